// ---- rtl/rpms_ctrl.sv ----
/*
  reset sequencer, power-fault mode selector and program security latch.
  assumes pins arrive asynchronously, firmware and flash strobes come
  from logic on clk, and the crystal is slow enough to be sampled.
*/
`timescale 1ns/1ps
`default_nettype none

module rpms_ctrl
#(
  // crystal edges of the reset timer; shorten for simulation
  parameter int RstXtalCycles = rpms_pkg::RESET_XTAL_CYCLES
)
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire rpms_pkg::rpms_pins_t pins,
  input  wire logic                fwBrownout,
  input  wire logic                prebootDone,
  input  wire logic                secEnable,
  input  wire logic                eraseDone,
  input  wire rpms_pkg::rpms_emu_t  emuReq,
  output rpms_pkg::rpms_core_t     core,
  output logic [15:0]              bootAddr,
  output logic                     secured,
  output logic                     emuGrant,
  output logic                     emuBlock
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [rpms_pkg::PIN_W-1:0] pinVec;    // synchronised pin levels
  rpms_pkg::rpms_pins_t       pinS;      // same, as a struct

  rpms_sync
  #(
    .W   (rpms_pkg::PIN_W),
    .RST (rpms_pkg::PIN_RST)
  )
  u_sync
  (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (pins),
    .dout  (pinVec)
  );

  assign pinS = rpms_pkg::rpms_pins_t'(pinVec);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // pick the mode a power fault leads to
  function automatic rpms_pkg::rpms_state_t faultMode
  (
    input logic fw,
    input logic run,
    input logic slp
  );
    if (fw && run)
      faultMode = rpms_pkg::ST_BROWN;
    else if (fw && slp)
      faultMode = rpms_pkg::ST_SLEEP;
    else
      faultMode = rpms_pkg::ST_HOLD;
  endfunction

  // last value of the reset timer before expiry
  localparam logic [rpms_pkg::CNT_W-1:0] CNT_LAST =
    rpms_pkg::CNT_W'(RstXtalCycles - 1);

  rpms_pkg::rpms_regs_t q;       // current state
  rpms_pkg::rpms_regs_t d;       // next state
  logic                 xtalRise; // crystal rising edge seen this cycle

  assign xtalRise = pinS.xtalClk & ~q.xtalPrev;

  ////////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb
  begin
    d           = q;
    d.bootPulse = 1'b0;
    d.xtalPrev  = pinS.xtalClk;
    case (q.state)
      rpms_pkg::ST_HOLD:
      begin
        // counter cleared so a new release counts from zero
        d.cnt = rpms_pkg::CNT_RST;
        // erase already done, this reset completes the unlock
        if (q.erasePend)
        begin
          d.secured   = 1'b0;
          d.erasePend = 1'b0;
        end
        // leave only with pin low and supply above threshold
        if (!pinS.resetPin && !pinS.senseBelow)
          d.state = rpms_pkg::ST_WAIT;
      end
      rpms_pkg::ST_WAIT:
      begin
        if (pinS.resetPin || pinS.senseBelow)
          d.state = rpms_pkg::ST_HOLD;
        else if (xtalRise)
        begin
          // count only crystal edges, not system clocks
          if (q.cnt == CNT_LAST)
          begin
            d.state     = rpms_pkg::ST_PREBOOT;
            d.bootPulse = 1'b1;
            d.cnt       = rpms_pkg::CNT_RST;
          end
          else
            d.cnt = q.cnt + 1'b1;
        end
      end
      rpms_pkg::ST_PREBOOT:
      begin
        // security latch opens only in this window
        if (secEnable)
          d.secured = 1'b1;
        if (pinS.resetPin)
          d.state = rpms_pkg::ST_HOLD;
        else if (pinS.senseBelow)
          d.state = faultMode(fwBrownout, pinS.backupRun,
                              pinS.backupSleep);
        else if (prebootDone)
          d.state = rpms_pkg::ST_RUN;
      end
      rpms_pkg::ST_RUN:
      begin
        if (pinS.resetPin)
          d.state = rpms_pkg::ST_HOLD;
        else if (pinS.senseBelow)
          d.state = faultMode(fwBrownout, pinS.backupRun,
                              pinS.backupSleep);
      end
      rpms_pkg::ST_BROWN:
      begin
        // supply back: resume; backup sags: fall to a lower mode
        if (pinS.resetPin)
          d.state = rpms_pkg::ST_HOLD;
        else if (!pinS.senseBelow)
          d.state = rpms_pkg::ST_RUN;
        else if (!pinS.backupRun)
          d.state = pinS.backupSleep ? rpms_pkg::ST_SLEEP
                                     : rpms_pkg::ST_HOLD;
      end
      rpms_pkg::ST_SLEEP:
      begin
        // the core has lost its context, so every exit reboots
        if (pinS.resetPin || !pinS.senseBelow || !pinS.backupSleep)
          d.state = rpms_pkg::ST_HOLD;
      end
      default:
      begin
        d.state = rpms_pkg::ST_HOLD;
      end
    endcase
    // set wins: an erase finishing in a clearing cycle is kept
    if (eraseDone)
      d.erasePend = 1'b1;
  end

  // state register; security restarts clear and is re-armed by preboot
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= rpms_pkg::REGS_RST;
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, decoded from the state register; the emulator gate also from the request

  // hold and timer phases share one decode; the core cannot tell them apart
  logic inReset;   // hold or timer phase
  assign inReset = (q.state == rpms_pkg::ST_HOLD) ||
                   (q.state == rpms_pkg::ST_WAIT);

  // halted in reset and in sleep; crystal and clock keep running
  assign core.coreHalt  = inReset ||
                          (q.state == rpms_pkg::ST_SLEEP);
  assign core.ioDefault = inReset;
  assign core.preboot   = (q.state == rpms_pkg::ST_PREBOOT);
  assign core.bootStart = q.bootPulse;
  assign core.mpuSlow   = (q.state == rpms_pkg::ST_BROWN);
  assign core.afeEnable = (q.state == rpms_pkg::ST_PREBOOT) ||
                          (q.state == rpms_pkg::ST_RUN);
  assign core.rtcOnly   = (q.state == rpms_pkg::ST_SLEEP);
  assign bootAddr       = rpms_pkg::BOOT_ADDR;
  assign secured        = q.secured;

  // emulator gate; combinational so a request is judged the same cycle
  // a request in the cycle the latch is set is judged on the old value,
  // so preboot code should set security before the port is opened
  assign emuGrant = emuReq.valid &&
                    (!q.secured || emuReq.globalErase);
  assign emuBlock = emuReq.valid && q.secured &&
                    !emuReq.globalErase;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_pin_halts_core:
  assert property (pinS.resetPin |=> core.coreHalt)
  else $error("reset pin high but core not halted");

  a_reset_io_default:
  assert property (pinS.resetPin |=>
                   core.ioDefault && !core.afeEnable && !core.preboot)
  else $error("register space not at defaults in reset");

  a_timer_full_count:
  assert property ((q.state == rpms_pkg::ST_WAIT) &&
                   (d.state == rpms_pkg::ST_PREBOOT) |->
                   (q.cnt == CNT_LAST) && xtalRise)
  else $error("reset timer expired early");

  a_boot_start_pulse:
  assert property (core.bootStart |->
                   core.preboot && !core.coreHalt &&
                   $past(q.state) == rpms_pkg::ST_WAIT &&
                   bootAddr == rpms_pkg::BOOT_ADDR ##1
                   !core.bootStart)
  else $error("boot start without timer expiry");

  a_low_supply_run_mode_entry:
  assert property ((q.state == rpms_pkg::ST_RUN) && !pinS.resetPin &&
                   pinS.senseBelow && fwBrownout && pinS.backupRun |=>
                   core.mpuSlow && !core.afeEnable)
  else $error("fault with backup did not enter low supply mode");

  a_sleep_entry:
  assert property ((q.state == rpms_pkg::ST_RUN) && !pinS.resetPin &&
                   pinS.senseBelow && fwBrownout && !pinS.backupRun &&
                   pinS.backupSleep |=> core.rtcOnly && core.coreHalt)
  else $error("weak backup did not enter sleep");

  a_fault_reset:
  assert property ((q.state == rpms_pkg::ST_RUN) && pinS.senseBelow &&
                   (!fwBrownout ||
                    (!pinS.backupRun && !pinS.backupSleep)) |=>
                   core.ioDefault)
  else $error("unsupported fault did not reset");

  a_emu_secured:
  assert property (q.secured && emuReq.valid && !emuReq.globalErase |->
                   !emuGrant && emuBlock)
  else $error("secured emulator operation not blocked");

  a_secure_preboot:
  assert property ($rose(q.secured) |->
                   $past(q.state) == rpms_pkg::ST_PREBOOT &&
                   $past(secEnable))
  else $error("security set outside preboot");

  a_secure_clear:
  assert property ($fell(q.secured) |->
                   $past(q.erasePend) &&
                   $past(q.state) == rpms_pkg::ST_HOLD)
  else $error("security cleared without erase and reset");

  a_timer_restart:
  assert property ((q.state == rpms_pkg::ST_WAIT) && pinS.resetPin |=>
                   (q.state == rpms_pkg::ST_HOLD) ##1
                   (q.cnt == rpms_pkg::CNT_RST))
  else $error("timer not restarted by pin");

  a_brown_recover:
  assert property ((q.state == rpms_pkg::ST_BROWN) && !pinS.resetPin &&
                   !pinS.senseBelow |=> core.afeEnable && !core.mpuSlow)
  else $error("low supply mode did not resume after recovery");

  a_sleep_exit:
  assert property ((q.state == rpms_pkg::ST_SLEEP) &&
                   (pinS.resetPin || !pinS.senseBelow ||
                    !pinS.backupSleep) |=>
                   core.ioDefault && !core.rtcOnly)
  else $error("sleep exit did not reboot through reset");

  c_boot: cover property (core.bootStart);
  c_brown: cover property ($rose(core.mpuSlow));
  c_sleep: cover property ($rose(core.rtcOnly));
  c_block: cover property (emuBlock);

endmodule

`default_nettype wire

// ---- rtl/rpms_pkg.sv ----
/*
  shared constants and types for the reset, power-fault and program
  security controller.
  assumes a single 50 MHz system clock and a slow crystal input that is
  sampled, not used as a clock.
*/
package rpms_pkg;

  // crystal edges the reset timer must see after the pin is released
  localparam int RESET_XTAL_CYCLES = 4096;
  // width of the reset timer counter
  localparam int CNT_W = 16;
  // reset value of the reset timer counter
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  // program address the core starts from after the timer expires
  localparam logic [15:0] BOOT_ADDR = 16'h0000;
  // number of pin inputs that pass the synchroniser
  localparam int PIN_W = 5;
  // synchroniser reset value: reset pin high, everything else low
  localparam logic [PIN_W-1:0] PIN_RST = 5'h10;

  // sequencer states
  typedef enum logic [2:0] {
    ST_HOLD    = 3'b000,  // reset pin high or fault reset
    ST_WAIT    = 3'b001,  // pin released, timer counting
    ST_PREBOOT = 3'b010,  // core runs preboot code
    ST_RUN     = 3'b011,  // primary boot and normal running
    ST_BROWN   = 3'b100,  // low supply run mode
    ST_SLEEP   = 3'b101   // only real-time clock alive
  } rpms_state_t;

  // pins from outside the clock domain
  typedef struct packed {
    logic resetPin;      // external reset, high = reset
    logic xtalClk;       // crystal oscillator level
    logic senseBelow;    // sense input below fault threshold level
    logic backupRun;     // backup supply can carry low supply run mode
    logic backupSleep;   // backup supply can carry sleep
  } rpms_pins_t;

  // outputs towards core, analog front end and clocking
  typedef struct packed {
    logic coreHalt;      // processor and digital logic stopped
    logic ioDefault;     // register space forced to defaults
    logic preboot;       // preboot interval in progress
    logic bootStart;     // one-cycle pulse: fetch from boot address
    logic mpuSlow;       // processor on crystal rate clock
    logic afeEnable;     // measurement front end powered
    logic rtcOnly;       // sleep: only real-time clock running
  } rpms_core_t;

  // emulator port request
  typedef struct packed {
    logic valid;         // operation requested
    logic globalErase;   // the operation is a global flash erase
  } rpms_emu_t;

  // full state of the controller
  typedef struct packed {
    rpms_state_t       state;
    logic [CNT_W-1:0]  cnt;
    logic              xtalPrev;
    logic              secured;
    logic              erasePend;
    logic              bootPulse;
  } rpms_regs_t;

  // reset value of the controller state
  localparam rpms_regs_t REGS_RST = '{
    state:     ST_HOLD,
    cnt:       CNT_RST,
    xtalPrev:  1'b0,
    secured:   1'b0,
    erasePend: 1'b0,
    bootPulse: 1'b0
  };

endpackage

// ---- rtl/rpms_sync.sv ----
/*
  three-stage pin synchroniser with agreement filter.
  assumes the inputs are asynchronous levels; the output moves only when
  the second and third stages agree.
*/
`timescale 1ns/1ps
`default_nettype none

module rpms_sync
#(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  // all synchroniser stages
  typedef struct packed {
    logic [W-1:0] s1;   // first stage, read only by s2
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;    // filtered level
  } rpms_sync_regs_t;

  rpms_sync_regs_t q;
  rpms_sync_regs_t d;

  ////////////////////////////////////////////////////////////////////////
  // next stage values; a bit follows only when s2 and s3 agree
  always_comb
  begin
    d    = q;
    d.s1 = din;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.o  = (q.s2 & q.s3) | (q.o & (q.s2 | q.s3));
  end

  // registers, all stages start at the reset value
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '{s1: RST, s2: RST, s3: RST, o: RST};
    else
      q <= d;
  end

  assign dout = q.o;

endmodule

`default_nettype wire

// ---- dv/rpms_partner.sv ----
/*
  far side model: external reset driver, supply fault comparator,
  backup supply monitor and the free running crystal.
  assumes the bench sets the requested levels away from clk's edge.
*/
`timescale 1ns/1ps
`default_nettype none

module rpms_partner
#(
  parameter int XtalHalf = 4
)
(
  input  wire logic            clk,
  input  wire logic            rstReq,
  input  wire logic            lowSense,
  input  wire logic            runOk,
  input  wire logic            sleepOk,
  output rpms_pkg::rpms_pins_t pins
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] divQ;   // crystal half period divider
  logic       xtalQ;  // crystal level, runs even through reset

  initial divQ = 8'h00;
  initial xtalQ = 1'b0;

  // crystal much slower than clk so the sampler never misses an edge
  always @(negedge clk)
  begin
    if (divQ == 8'(XtalHalf - 1))
    begin
      divQ <= 8'h00;
      xtalQ <= ~xtalQ;
    end
    else
      divQ <= divQ + 8'h01;
  end

  // levels are held, never pulsed, so the filter always passes them
  assign pins.resetPin = rstReq;
  assign pins.xtalClk = xtalQ;
  assign pins.senseBelow = lowSense;
  assign pins.backupRun = runOk;
  assign pins.backupSleep = sleepOk;
endmodule

`default_nettype wire

// ---- dv/testbench.sv ----
/*
  self-checking bench for the reset, power fault and security controller.
  assumes a short reset timer and the partner model on the pins.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int NCyc = 4;                  // shortened reset timer
  localparam int XHalf = 4;                 // crystal half period in clk
  localparam int Lo = (NCyc - 1) * 2 * XHalf;
  localparam int Hi = NCyc * 2 * XHalf + 12; // plus sync latency

  logic                  clk, rst_n, fwBrownout, prebootDone;
  logic                  secEnable, eraseDone;
  logic                  rstReq, lowSense, runOk, sleepOk;
  rpms_pkg::rpms_emu_t   emuReq;
  rpms_pkg::rpms_pins_t  pins;
  rpms_pkg::rpms_core_t  core;
  logic [15:0]           bootAddr;
  logic                  secured, emuGrant, emuBlock;
  int                    errCount, checksDone;
  logic [31:0]           seed;

  ////////////////////////////////////////////////////////////////////////
  rpms_partner #(.XtalHalf(XHalf)) u_rpms_partner (.clk(clk),
    .rstReq(rstReq), .lowSense(lowSense), .runOk(runOk),
    .sleepOk(sleepOk), .pins(pins));

  rpms_ctrl #(.RstXtalCycles(NCyc)) u_rpms_ctrl (.clk(clk), .rst_n(rst_n),
    .pins(pins), .fwBrownout(fwBrownout), .prebootDone(prebootDone),
    .secEnable(secEnable), .eraseDone(eraseDone), .emuReq(emuReq),
    .core(core), .bootAddr(bootAddr), .secured(secured),
    .emuGrant(emuGrant), .emuBlock(emuBlock));

  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // mode vector: slow clock, rtc only, defaults, halt, front end
  function automatic logic [4:0] mode();
    return {core.mpuSlow, core.rtcOnly, core.ioDefault, core.coreHalt,
            core.afeEnable};
  endfunction

  // k = {firmware support, backup run, backup sleep}
  function automatic logic [4:0] expFault(input logic [2:0] k);
    if (k[2] && k[1])
      return 5'h10;
    if (k[2] && k[0])
      return 5'h0a;
    return 5'h06;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string msg);
    checksDone++;
    if (got !== exp)
    begin
      errCount++;
      $display("wrong value at %0t: %s got %h want %h", $time, msg, got,
               exp);
    end
  endtask

  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // pin high long enough to pass the filter, then look at the halt
  task automatic hold();
    rstReq = 1'b1;
    repeat (10) @(negedge clk);
    check(16'(mode()), 16'h6, "held");
  endtask

  // release at a random crystal phase, walk preboot into running
  task automatic boot(input logic setSec);
    int n;
    n = 0;
    seed = xs(seed);
    repeat (seed[2:0]) @(negedge clk);
    rstReq = 1'b0;
    while (core.bootStart !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    check(16'(n >= Lo && n <= Hi), 16'h1, "timer span");
    check(16'({core.preboot, core.coreHalt, core.ioDefault}), 16'h4,
          "boot");
    check(bootAddr, 16'h0000, "boot address");
    secEnable = setSec;
    @(negedge clk);
    secEnable = 1'b0;
    check(16'(core.bootStart), 16'h0, "start pulse");
    prebootDone = 1'b1;
    @(negedge clk);
    prebootDone = 1'b0;
    @(negedge clk);
    check(16'(mode()), 16'h1, "running");
  endtask

  // random emulator traffic, answer is combinational
  task automatic emuLoop(input logic sec);
    logic v, ge;
    for (int i = 0; i < 12; i++)
    begin
      seed = xs(seed);
      // first two requests fixed: plain operation, then global erase
      v = (i < 2) ? 1'b1 : seed[0];
      ge = (i < 2) ? i[0] : seed[1];
      emuReq = '{valid: v, globalErase: ge};
      #1;
      check(16'({emuGrant, emuBlock}), 16'({v & (~sec | ge),
            v & sec & ~ge}), "emulator");
      @(negedge clk);
    end
    emuReq = '{valid: 1'b0, globalErase: 1'b0};
  endtask

  ////////////////////////////////////////////////////////////////////////
  // watchdog: all tests take about a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    errCount++;
    wrapUp();
  end

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    {fwBrownout, prebootDone, secEnable, eraseDone} = 4'h0;
    {rstReq, lowSense, runOk, sleepOk} = 4'h8;
    emuReq = '{valid: 1'b0, globalErase: 1'b0};
    errCount = 0;
    checksDone = 0;
    seed = 32'h724f4436;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    check(16'(mode()), 16'h6, "power-on hold");
    boot(1'b0);
    // enable after preboot has no effect
    secEnable = 1'b1;
    @(negedge clk);
    secEnable = 1'b0;
    repeat (3) @(negedge clk);
    check(16'(secured), 16'h0, "late enable");
    emuLoop(1'b0);
    $display("test boot done");
    // pin raised again while the timer counts
    hold();
    rstReq = 1'b0;
    // two or three crystal rises counted, still short of expiry, so a
    // timer that kept its count would finish the next boot too early
    repeat (20) @(negedge clk);
    hold();
    boot(1'b0);
    $display("test retrigger done");
    hold();
    boot(1'b1);
    check(16'(secured), 16'h1, "secured");
    emuLoop(1'b1);
    hold();
    boot(1'b0);
    check(16'(secured), 16'h1, "reset alone");
    eraseDone = 1'b1;
    @(negedge clk);
    eraseDone = 1'b0;
    repeat (4) @(negedge clk);
    check(16'(secured), 16'h1, "erase alone");
    hold();
    check(16'(secured), 16'h0, "erase then reset");
    boot(1'b0);
    $display("test security done");
    // every support and backup combination under a fault
    for (int k = 0; k < 8; k++)
    begin
      {fwBrownout, runOk, sleepOk} = 3'(k);
      lowSense = 1'b1;
      repeat (10) @(negedge clk);
      check(16'(mode()), 16'(expFault(3'(k))), "fault mode");
      // leave low supply mode: supply back resumes, lost backup sleeps
      if (k == 6 || k == 7)
      begin
        if (k[0])
          runOk = 1'b0;
        else
          lowSense = 1'b0;
        repeat (10) @(negedge clk);
        check(16'(mode()), k[0] ? 16'h0a : 16'h01, "fault exit");
      end
      lowSense = 1'b0;
      hold();
      boot(1'b0);
    end
    $display("test fault done");
    wrapUp();
  end
endmodule

`default_nettype wire
